// file: logic/vfb_control.sv
/*
 Pointer, control and storage logic of a 4-bit serial video field buffer.
 Assumes all pins are asynchronous to mclk_in and port clocks run far slower
 (at least six mclk_in periods per port clock).
*/
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module vfb_control
  import vfb_pkg::*;
#(
  parameter int LINES_MAX = FIELD_LINES_MAX
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic mode_async_in,
  input wire logic write_clock_in,
  input wire logic read_clock_in,
  input wire logic write_pointer_clear_n_in,
  input wire logic read_pointer_clear_n_in,
  input wire logic write_line_reset_n_in,
  input wire logic read_line_reset_n_in,
  input wire logic write_line_jump_in,
  input wire logic read_line_jump_in,
  input wire logic write_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic [1:0] line_count_sel_in,
  input wire logic [3:0] last_line_size_sel_in,
  input wire logic [DATA_W-1:0] write_data_in,
  output logic [DATA_W-1:0] read_data_out,
  output logic read_data_oe_out,
  output logic [1:0] last_line_size_sel_out,
  output logic [1:0] last_line_size_sel_oe_out
);
  localparam int MEM_WORDS = LINES_MAX * int'(LINE_WORDS);

  logic [PIN_W-1:0] pins_s;
  logic async_s, wclk_s, rclk_s, we_n_s, oe_n_s;
  logic [1:0] ls_s;
  logic [3:0] bs_s;
  logic [DATA_W-1:0] din_s;
  logic wclk_prev_r, rclk_prev_r;
  logic [1:0] tick;
  logic rtick;
  vfb_port_in_t port_in [2];
  vfb_ptr_t st_r [2];
  vfb_ptr_t st_nxt [2];
  logic [LINE_W-1:0] max_line;
  logic [BIT_W-1:0] last_idx;

  vfb_sync2 #(.WIDTH(PIN_W)) u_sync (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .pins_in({mode_async_in, write_clock_in, read_clock_in, write_pointer_clear_n_in,
              read_pointer_clear_n_in, write_line_reset_n_in, read_line_reset_n_in,
              write_line_jump_in, read_line_jump_in, write_enable_n_in, output_enable_n_in,
              line_count_sel_in, last_line_size_sel_in, write_data_in}),
    .pins_out(pins_s)
  );

  assign {async_s, wclk_s, rclk_s} = pins_s[20:18];
  assign {we_n_s, oe_n_s, ls_s, bs_s, din_s} = pins_s[11:0];
  assign port_in[0] = '{clr_n: pins_s[17], lrst_n: pins_s[15], jump: async_s & pins_s[13],
                        hold: async_s & bs_s[2]};
  assign port_in[1] = '{clr_n: pins_s[16], lrst_n: pins_s[14], jump: async_s & pins_s[12],
                        hold: async_s & bs_s[3]};

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      wclk_prev_r <= 1'b0;
      rclk_prev_r <= 1'b0;
    end else begin
      wclk_prev_r <= wclk_s;
      rclk_prev_r <= rclk_s;
    end
  end

  // Port clock rising edges; read port idles in synchronous mode
  assign tick[0] = wclk_s & ~wclk_prev_r;
  assign tick[1] = (async_s != MODE_SYNC) & rclk_s & ~rclk_prev_r;
  assign rtick = (async_s == MODE_SYNC) ? tick[0] : tick[1];

  assign max_line = LINES_BASE + {7'h00, ls_s} - 9'h001;
  assign last_idx = LAST_LEN_BASE + {6'h00, bs_s} - 10'h001;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic [BIT_W-1:0] end_idx;
      logic [LINE_W-1:0] adv_line;

      // Async lines are always full length; sync last line follows the size code
      always_comb begin
        if (async_s != MODE_SYNC || st_r[p].line != max_line || bs_s == SIZE_CODE_BAD) begin
          end_idx = LINE_LAST_WORD;
        end else begin
          end_idx = last_idx;
        end
      end

      // Next line: held, or one plus pending jumps, wrapping past field end
      always_comb begin
        if (st_r[p].held) begin
          adv_line = st_r[p].line;
        end else if ({1'b0, st_r[p].line} + {1'b0, st_r[p].jcnt} + 10'h001 > {1'b0, max_line}) begin
          adv_line = '0;
        end else begin
          adv_line = st_r[p].line + st_r[p].jcnt + 9'h001;
        end
      end

      always_comb begin
        st_nxt[p] = st_r[p];
        if (port_in[p].jump && st_r[p].jarm) begin
          st_nxt[p].jcnt = st_r[p].jcnt + 9'h001;
          st_nxt[p].jarm = 1'b0;
        end else if (!port_in[p].jump) begin
          st_nxt[p].jarm = 1'b1;
        end
        if (st_r[p].held) begin
          st_nxt[p].hcnt = st_r[p].hcnt + 10'h001;
          if (st_r[p].hcnt == LINE_LAST_WORD) begin
            st_nxt[p].held = 1'b0;
          end
        end else if (port_in[p].hold) begin
          st_nxt[p].held = 1'b1;
          st_nxt[p].hcnt = '0;
        end
        if (!port_in[p].clr_n) begin
          st_nxt[p] = PTR_RESET;
        end else if (!port_in[p].lrst_n) begin
          st_nxt[p].bitp = '0;
          if (!st_r[p].lrst_seen) begin
            st_nxt[p].line = adv_line;
            st_nxt[p].jcnt = '0;
            st_nxt[p].held = 1'b0;
          end
          st_nxt[p].lrst_seen = 1'b1;
        end else begin
          st_nxt[p].lrst_seen = 1'b0;
          if (st_r[p].bitp >= end_idx) begin
            st_nxt[p].bitp = '0;
            st_nxt[p].line = adv_line;
            st_nxt[p].jcnt = '0;
          end else begin
            st_nxt[p].bitp = st_r[p].bitp + 10'h001;
          end
        end
        st_nxt[p].carry = (async_s != MODE_SYNC) && (st_nxt[p].bitp == LINE_LAST_WORD);
      end

      always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
          st_r[p] <= PTR_RESET;
        end else if (tick[p]) begin
          st_r[p] <= st_nxt[p];
        end
      end
    end
  endgenerate

  // Carry pins drive only in asynchronous mode
  always_comb begin
    last_line_size_sel_oe_out = (async_s != MODE_SYNC) ? 2'h3 : 2'h0;
    last_line_size_sel_out = {st_r[1].carry, st_r[0].carry};
  end

  // Half register staging and background transfer into the field array
  logic [DATA_W-1:0] stage_mem [int'(LINE_WORDS)];
  logic [DATA_W-1:0] field_mem [MEM_WORDS];
  logic half_ok_r;
  logic half_start, half_end, half_good;
  logic copy_busy_r;
  logic [BIT_W-1:0] copy_src_r, copy_idx_r, copy_len_r;
  logic [ADDR_W-1:0] copy_dst_r;
  logic [ADDR_W-1:0] waddr, raddr;
  logic [DATA_W-1:0] rdata_r;

  assign half_start = (st_r[0].bitp == '0) || (st_r[0].bitp == HALF_WORDS);
  assign half_end = (st_r[0].bitp == HALF_WORDS - 10'h001) || (st_r[0].bitp == g_port[0].end_idx);
  assign half_good = (half_start | half_ok_r) & ~we_n_s & port_in[0].clr_n & port_in[0].lrst_n;
  assign waddr = ADDR_W'(st_r[0].line * LINE_WORDS);
  assign raddr = (async_s == MODE_SYNC) ? ADDR_W'(waddr + {8'h00, st_r[0].bitp}) :
                 ADDR_W'(ADDR_W'(st_r[1].line * LINE_WORDS) + {8'h00, st_r[1].bitp});

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      half_ok_r <= 1'b0;
    end else if (tick[0]) begin
      half_ok_r <= half_good & ~half_end;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (tick[0] && !we_n_s) begin
      stage_mem[st_r[0].bitp] <= din_s;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      copy_busy_r <= 1'b0;
      copy_src_r <= '0;
      copy_idx_r <= '0;
      copy_len_r <= '0;
      copy_dst_r <= '0;
    end else if (tick[0] && half_end && half_good) begin
      copy_busy_r <= 1'b1;
      copy_src_r <= (st_r[0].bitp < HALF_WORDS) ? 10'h000 : HALF_WORDS;
      copy_dst_r <= ADDR_W'(waddr + ((st_r[0].bitp < HALF_WORDS) ? 18'h00000 : {8'h00, HALF_WORDS}));
      copy_len_r <= (st_r[0].bitp < HALF_WORDS) ? st_r[0].bitp : st_r[0].bitp - HALF_WORDS;
      copy_idx_r <= '0;
    end else if (copy_busy_r) begin
      copy_idx_r <= copy_idx_r + 10'h001;
      if (copy_idx_r == copy_len_r) begin
        copy_busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (copy_busy_r) begin
      field_mem[ADDR_W'(copy_dst_r + {8'h00, copy_idx_r})] <= stage_mem[BIT_W'(copy_src_r + copy_idx_r)];
    end
  end

  // Read side samples the array before any pending transfer lands
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rdata_r <= '0;
    end else if (rtick) begin
      rdata_r <= field_mem[raddr];
    end
  end

  assign read_data_out = rdata_r;
  assign read_data_oe_out = ~oe_n_s;

  // Helper: mclk cycles the write clear has been low
  logic [11:0] write_pointer_clear_n_low_cnt_r;
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || port_in[0].clr_n) begin
      write_pointer_clear_n_low_cnt_r <= '0;
    end else if (write_pointer_clear_n_low_cnt_r != 12'hFFF) begin
      write_pointer_clear_n_low_cnt_r <= write_pointer_clear_n_low_cnt_r + 12'h001;
    end
  end

  property p_last_len;
    @(posedge mclk_in) disable iff (!rst_b_in)
    tick[0] && async_s == MODE_SYNC && st_r[0].line == max_line && bs_s != SIZE_CODE_BAD &&
    port_in[0].clr_n && port_in[0].lrst_n && st_r[0].bitp == last_idx
    |=> st_r[0].bitp == '0 && st_r[0].line == '0;
  endproperty
  a_last_len: assert property (p_last_len) else $error("short last line did not wrap");

  property p_field_wrap;
    @(posedge mclk_in) disable iff (!rst_b_in)
    tick[1] && st_r[1].line == max_line && !st_r[1].held && st_r[1].jcnt == '0 &&
    port_in[1].clr_n && port_in[1].lrst_n && st_r[1].bitp == LINE_LAST_WORD
    |=> st_r[1].line == '0;
  endproperty
  a_field_wrap: assert property (p_field_wrap) else $error("read field did not wrap");

  property p_async_len;
    @(posedge mclk_in) disable iff (!rst_b_in)
    tick[0] && async_s != MODE_SYNC && port_in[0].clr_n && port_in[0].lrst_n &&
    st_r[0].bitp == LINE_LAST_WORD - 10'h001 |=> st_r[0].bitp == LINE_LAST_WORD;
  endproperty
  a_async_len: assert property (p_async_len) else $error("async line shorter than 910");

  property p_carry;
    @(posedge mclk_in) disable iff (!rst_b_in)
    tick[0] && async_s != MODE_SYNC && $stable(async_s)
    |=> last_line_size_sel_out[0] == (st_r[0].bitp == LINE_LAST_WORD);
  endproperty
  a_carry: assert property (p_carry) else $error("write carry mismatch");

  property p_bit_adv;
    @(posedge mclk_in) disable iff (!rst_b_in)
    tick[0] && we_n_s && port_in[0].clr_n && port_in[0].lrst_n && st_r[0].bitp < g_port[0].end_idx
    |=> st_r[0].bitp == $past(st_r[0].bitp) + 10'h001;
  endproperty
  a_bit_adv: assert property (p_bit_adv) else $error("write pointer stalled");

  property p_clear;
    @(posedge mclk_in) disable iff (!rst_b_in)
    tick[1] && !port_in[1].clr_n |=> st_r[1].bitp == '0 && st_r[1].line == '0 && !st_r[1].held;
  endproperty
  a_clear: assert property (p_clear) else $error("read clear failed");

  property p_oe;
    @(posedge mclk_in) disable iff (!rst_b_in)
    $rose(oe_n_s) |-> !read_data_oe_out ##1 (!read_data_oe_out || $fell(oe_n_s));
  endproperty
  a_oe: assert property (p_oe) else $error("outputs driven while disabled");

  property p_sync_ignore;
    @(posedge mclk_in) disable iff (!rst_b_in)
    async_s == MODE_SYNC && $past(async_s) == MODE_SYNC |-> $stable(st_r[1]);
  endproperty
  a_sync_ignore: assert property (p_sync_ignore) else $error("read port moved in sync mode");

  property p_hold;
    @(posedge mclk_in) disable iff (!rst_b_in)
    tick[0] && st_r[0].held && port_in[0].clr_n && port_in[0].lrst_n &&
    st_r[0].bitp == LINE_LAST_WORD |=> st_r[0].line == $past(st_r[0].line);
  endproperty
  a_hold: assert property (p_hold) else $error("held line advanced");

  property p_pins;
    @(posedge mclk_in) disable iff (!rst_b_in)
    async_s == MODE_SYNC |-> last_line_size_sel_oe_out == 2'h0;
  endproperty
  a_pins: assert property (p_pins) else $error("size pins driven in sync mode");

  c_copy: cover property (@(posedge mclk_in) disable iff (!rst_b_in) $fell(copy_busy_r));
  c_carry: cover property (@(posedge mclk_in) disable iff (!rst_b_in) $rose(last_line_size_sel_out[1]));
  c_jump: cover property (@(posedge mclk_in) disable iff (!rst_b_in) tick[0] && st_r[0].jcnt != '0);
  c_long_clr: cover property (@(posedge mclk_in) disable iff (!rst_b_in) write_pointer_clear_n_low_cnt_r == 12'(CLR_CYC));
endmodule : vfb_control
`default_nettype wire

// file: logic/vfb_pkg.sv
/*
 Constants, field layouts and carrier types of the video field buffer control.
 Assumes nothing of its surroundings; imported whole by vfb_control and the bench modules, not by vfb_sync2.
*/
`default_nettype none
package vfb_pkg;
  localparam int DATA_W = 4;
  localparam int BIT_W = 10;
  localparam int LINE_W = 9;
  localparam int ADDR_W = 18;
  localparam int PIN_W = 21;
  // Word pointer landmarks within one scan line
  localparam logic [BIT_W-1:0] LINE_LAST_WORD = 10'h38D;
  localparam logic [BIT_W-1:0] HALF_WORDS = 10'h1C7;
  localparam logic [BIT_W-1:0] LAST_LEN_BASE = 10'h37F;
  localparam logic [ADDR_W-1:0] LINE_WORDS = 18'h0038E;
  localparam logic [3:0] SIZE_CODE_BAD = 4'h0;
  // Field height select base and largest field
  localparam logic [LINE_W-1:0] LINES_BASE = 9'h104;
  localparam int FIELD_LINES_MAX = 263;
  localparam logic MODE_SYNC = 1'b0;
  // Least pointer clear or line reset low time
  localparam int T_CLR_NS = 3000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLR_CYC = (T_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic clr_n;
    logic lrst_n;
    logic jump;
    logic hold;
  } vfb_port_in_t;

  typedef struct packed {
    logic [BIT_W-1:0] bitp;
    logic [LINE_W-1:0] line;
    logic held;
    logic [BIT_W-1:0] hcnt;
    logic jarm;
    logic [LINE_W-1:0] jcnt;
    logic lrst_seen;
    logic carry;
  } vfb_ptr_t;

  localparam vfb_ptr_t PTR_RESET = '{bitp: '0, line: '0, held: 1'b0, hcnt: '0, jarm: 1'b1,
                                     jcnt: '0, lrst_seen: 1'b0, carry: 1'b0};
endpackage : vfb_pkg
`default_nettype wire

// file: logic/vfb_sync2.sv
/*
 Two flip-flop synchroniser for a vector of pin levels.
 Assumes each bit is a level from outside the mclk_in domain.
*/
`timescale 1ns/100ps
`default_nettype none
module vfb_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] pins_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      meta_r <= '0;
      pins_out <= '0;
    end else begin
      meta_r <= pins_in;
      pins_out <= meta_r;
    end
  end
endmodule : vfb_sync2
`default_nettype wire

// file: tb/vfb_ctl_model.sv
/*
 Controller-side model that drives every pin of the video field buffer control.
 Assumes the bench calls tick once per port clock and set_mode for the mode pin.
*/
`timescale 1ns/100ps
`default_nettype none
module vfb_ctl_model
  import vfb_pkg::*;
(
  input wire logic mclk_in,
  input wire logic [1:0] carry_in,
  input wire logic [1:0] carry_oe_in,
  output logic mode_async_out,
  output logic write_clock_out,
  output logic read_clock_out,
  output logic write_pointer_clear_n_out,
  output logic read_pointer_clear_n_out,
  output logic write_line_reset_n_out,
  output logic read_line_reset_n_out,
  output logic write_line_jump_out,
  output logic read_line_jump_out,
  output logic write_enable_n_out,
  output logic output_enable_n_out,
  output logic [1:0] line_count_sel_out,
  output logic [3:0] last_line_size_sel_out,
  output logic [DATA_W-1:0] write_data_out
);
  logic [1:0] holds;
  // Field height never moves during the run
  assign line_count_sel_out = 2'h0;
  // Released carry pins float to the inverse of the last level
  assign last_line_size_sel_out = mode_async_out ? {holds, carry_in ^ ~carry_oe_in} : 4'hF;
  initial begin
    holds = 2'h0;
    mode_async_out = 1'b1;
    write_clock_out = 1'b0;
    read_clock_out = 1'b0;
    write_pointer_clear_n_out = 1'b1;
    read_pointer_clear_n_out = 1'b1;
    write_line_reset_n_out = 1'b1;
    read_line_reset_n_out = 1'b1;
    write_line_jump_out = 1'b0;
    read_line_jump_out = 1'b0;
    write_enable_n_out = 1'b1;
    output_enable_n_out = 1'b0;
    write_data_out = 4'h0;
  end
  task automatic set_mode(input logic m);
    @(posedge mclk_in);
    mode_async_out <= m;
  endtask : set_mode
  // One port clock: controls change with the rising pin edge
  task automatic tick(input bit rd, input logic [3:0] d, input logic en_n, input logic clr_n,
                      input logic lrst_n, input logic jump, input logic hold);
    @(posedge mclk_in);
    if (rd) begin
      read_pointer_clear_n_out <= clr_n;
      read_line_reset_n_out <= lrst_n;
      read_line_jump_out <= jump;
      output_enable_n_out <= en_n;
      holds[1] <= hold;
      read_clock_out <= 1'b1;
    end else begin
      write_pointer_clear_n_out <= clr_n;
      write_line_reset_n_out <= lrst_n;
      write_line_jump_out <= jump;
      write_enable_n_out <= en_n;
      write_data_out <= en_n ? ~d : d;
      holds[0] <= hold;
      write_clock_out <= 1'b1;
    end
    repeat (3) @(posedge mclk_in);
    write_clock_out <= 1'b0;
    read_clock_out <= 1'b0;
    repeat (3) @(posedge mclk_in);
  endtask : tick
endmodule : vfb_ctl_model
`default_nettype wire

// file: tb/vfb_control_tb.sv
/*
 Self-checking bench of the video field buffer control, line-level scenarios.
 Assumes vfb_ctl_model drives all pins; port clock period is seven mclk cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module vfb_control_tb
  import vfb_pkg::*;
;
  localparam int CLR_TICKS = CLR_CYC / 6 + 1;
  logic mclk;
  logic rst_b;
  bit mode_a;
  int n_fail;
  int comparisons;
  wire logic mode_async, wclk, rclk, write_pointer_clear_n_n, read_pointer_clear_n_n, write_line_reset_n_n, read_line_reset_n_n, wjump, rjump, we_n, oe_n;
  wire logic [1:0] lines_sel;
  wire logic [3:0] size_sel;
  wire logic [3:0] wdata;
  wire logic [3:0] rdata;
  wire logic rdata_oe;
  wire logic [1:0] size_out;
  wire logic [1:0] size_oe;

  vfb_ctl_model i_ctl (.mclk_in(mclk), .carry_in(size_out), .carry_oe_in(size_oe),
    .mode_async_out(mode_async), .write_clock_out(wclk), .read_clock_out(rclk),
    .write_pointer_clear_n_out(write_pointer_clear_n_n), .read_pointer_clear_n_out(read_pointer_clear_n_n),
    .write_line_reset_n_out(write_line_reset_n_n), .read_line_reset_n_out(read_line_reset_n_n),
    .write_line_jump_out(wjump), .read_line_jump_out(rjump), .write_enable_n_out(we_n),
    .output_enable_n_out(oe_n), .line_count_sel_out(lines_sel),
    .last_line_size_sel_out(size_sel), .write_data_out(wdata));

  vfb_control #(.LINES_MAX(260)) i_dut (.mclk_in(mclk), .rst_b_in(rst_b), .mode_async_in(mode_async),
    .write_clock_in(wclk), .read_clock_in(rclk), .write_pointer_clear_n_in(write_pointer_clear_n_n),
    .read_pointer_clear_n_in(read_pointer_clear_n_n), .write_line_reset_n_in(write_line_reset_n_n),
    .read_line_reset_n_in(read_line_reset_n_n), .write_line_jump_in(wjump), .read_line_jump_in(rjump),
    .write_enable_n_in(we_n), .output_enable_n_in(oe_n), .line_count_sel_in(lines_sel),
    .last_line_size_sel_in(size_sel), .write_data_in(wdata), .read_data_out(rdata),
    .read_data_oe_out(rdata_oe), .last_line_size_sel_out(size_out),
    .last_line_size_sel_oe_out(size_oe));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic conclude;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic cmp_data(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t read data %h expected %h", $time, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t flags %b expected %b", $time, got, exp);
    end
  endtask : cmp_flag

  function automatic logic [3:0] pat(input int s, input int i);
    return 4'(s * 5 + i + i / 16);
  endfunction : pat

  // Clear (lrst=0) or line reset (lrst=1) held low across enough port clocks
  task automatic clr(input bit rd, input bit lrst);
    for (int k = 0; k < CLR_TICKS; k++) begin
      i_ctl.tick(rd, 4'h0, !rd, lrst, !lrst, 1'b0, 1'b0);
    end
  endtask : clr

  // n port clocks from word 0, enable off for the first oe_hi; xs: expected read seed, negative for none
  task automatic run(input bit rd, input int n, input int s, input int xs, input int jat, input int hat,
                     input int oe_hi);
    for (int i = 0; i < n; i++) begin
      i_ctl.tick(rd, pat(s, i), i < oe_hi, 1'b1, 1'b1, i == jat, i == hat);
      if (xs >= 0 && (!rd || i >= oe_hi)) cmp_data(rdata, pat(xs, i));
      cmp_flag({1'b0, rdata_oe}, {1'b0, !rd || i >= oe_hi});
      if (mode_a) cmp_flag({1'b0, size_out[rd]}, {1'b0, (i % 910) == 908});
    end
  endtask : run

  initial begin
    n_fail = 0;
    comparisons = 0;
    mode_a = 1'b1;
    rst_b = 1'b0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    cmp_flag(size_oe, 2'h3);
    clr(0, 0);
    clr(1, 0);
    run(0, 910, 0, -1, -1, -1, 0);
    run(1, 910, 0, 0, -1, 229, 4);
    run(1, 910, 0, 0, -1, -1, 0);
    run(0, 910, 1, -1, -1, 229, 0);
    run(0, 910, 2, -1, -1, -1, 0);
    run(1, 910, 2, 2, -1, -1, 0);
    run(0, 460, 3, -1, 455, -1, 0);
    clr(0, 1);
    run(0, 455, 4, -1, -1, -1, 0);
    run(1, 455, 3, 3, 0, -1, 0);
    clr(1, 1);
    run(1, 455, 4, 4, -1, -1, 0);
    i_ctl.set_mode(1'b0);
    mode_a = 1'b0;
    repeat (4) @(posedge mclk);
    cmp_flag(size_oe, 2'h0);
    clr(0, 0);
    run(0, 455, 5, 0, -1, -1, 0);
    repeat (500) @(posedge mclk);
    clr(0, 0);
    clr(1, 1);
    run(0, 455, 6, 5, -1, -1, 0);
    clr(0, 0);
    run(0, 455, 7, 6, -1, -1, 1);
    clr(0, 0);
    run(0, 455, 8, 6, -1, -1, 0);
    conclude();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    conclude();
  end
endmodule : vfb_control_tb
`default_nettype wire
